// *** logic/cksr_pkg.sv ***
// Purpose: constants and types for the clock skew and recovery registers
// Assumes: byte-wide register port behind the serial control engine
// Notes: rule summary follows
// What this block does
// - cpu skew bits 7:5: 000 none, 001-011 earlier, 100-111 later, 150 ps
// - graphics skew bits 1:0: none, -150 ps, +150 ps, +300 ps
// - recovery source bit 7: 0 strap selection, 1 recovery N and M dividers
// - watchdog time-out switches to recovery frequency from selected source
// - recovery frequency uses 8-bit recovery N and 7-bit recovery M
// - ratio follows override: clear uses strap code, set uses software code
// - any update of recovery N or M changes the output frequency unless recovery is locked or a time-out comes in the same cycle
// - programmable enable set: output uses programmed N and programmed M
// - programmed M update starts a load; N alone starts nothing
// - programmed loads only need N and M at or above PROG_N_MIN and PROG_M_MIN; no 50 to 248 MHz check
// - time-out locks recovery; no frequency changes until enable clears
package cksr_pkg;
   localparam logic [7:0] OFS_SKEW   = 8'h0a;
   localparam logic [7:0] OFS_REC_N  = 8'h0b;
   localparam logic [7:0] OFS_REC_M  = 8'h0c;
   localparam logic [7:0] OFS_PROG_N = 8'h0d;
   localparam logic [7:0] RST_SKEW   = 8'h00;
   localparam logic [7:0] RST_REC_N  = 8'h00;
   localparam logic [7:0] RST_REC_M  = 8'h00;
   localparam logic [7:0] RST_PROG_N = 8'h00;
   localparam int CPU_SKEW_LSB = 5;
   localparam int CPU_SKEW_MSB = 7;
   localparam int GFX_SKEW_LSB = 0;
   localparam int GFX_SKEW_MSB = 1;
   localparam int REC_SEL_BIT  = 7;
   localparam int DIV_M_MSB    = 6;
   localparam int SKEW_STEP_PS = 150;
   localparam int FREQ_MIN_MHZ = 50;
   localparam int FREQ_MAX_MHZ = 248;

   // frequency target handed to the synthesizer
   typedef struct packed {
      logic       from_strap;
      logic [7:0] div_n;
      logic [6:0] div_m;
   } cksr_target_type;

   // one register write from the control engine
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cksr_write_type;
endpackage

// *** logic/cksr_byte_reg.sv ***
// Purpose: one writable register byte with reset value and clock enable
// Assumes: synchronous active-high reset
// Notes: used for each of the four stored bytes
`timescale 1ns/1ps
`default_nettype none
module cksr_byte_reg #(
   parameter int         WIDTH = 8,
   parameter logic [7:0] RESET = 8'h00
) (
   input  wire logic             ref_clk, // system clock
   input  wire logic             rst,     // synchronous reset
   input  wire logic             ce,      // clock enable
   input  wire logic             wr,      // write strobe
   input  wire logic [WIDTH-1:0] wdata,   // write data
   output logic      [WIDTH-1:0] q        // stored value
);
   if (WIDTH < 1 || WIDTH > 8)
      $error("cksr_byte_reg: WIDTH must be 1 to 8");

   // store on write, reset to the given value
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         q <= RESET[WIDTH-1:0];
      else if (ce && wr)
         q <= wdata;
   end
endmodule
`default_nettype wire

// *** logic/cksr_regs.sv ***
// Purpose: skew, recovery and programmed divider register slice
// Assumes: register port driven by the serial control engine
// Notes: targets and skews are registered for the synthesizer
`timescale 1ns/1ps
`default_nettype none
module cksr_regs
   import cksr_pkg::*;
#(
   parameter logic [7:0] PROG_N_MIN = 8'h01, // lowest legal programmed N
   parameter logic [6:0] PROG_M_MIN = 7'h01  // lowest legal programmed M
) (
   input  wire logic            ref_clk,        // system clock
   input  wire logic            rst,            // synchronous reset
   input  wire logic            ce,             // clock enable
   input  wire cksr_write_type  reg_wr,         // register write
   input  wire logic [7:0]      reg_raddr,      // register read address
   output logic      [7:0]      reg_rdata,      // read data, next cycle
   input  wire logic            watchdog_timeout,   // time-out pulse
   input  wire logic            watchdog_enable,    // watchdog enable bit
   input  wire logic            prog_freq_enable,   // programmable enable
   input  wire logic            prog_m_wr,          // programmed M written
   input  wire logic [6:0]      programmed_divider_m, // programmed M value
   input  wire logic            ratio_source_override, // ratio source
   input  wire logic [4:0]      strap_frequency_code,  // latched straps
   input  wire logic [4:0]      sw_select_code,     // software code
   output logic      [2:0]      cpu_skew,           // cpu skew code
   output logic      [1:0]      graphics_port_clock_delay, // gfx skew
   output cksr_target_type      freq_target,        // active target
   output logic                 freq_load,          // load pulse
   output logic                 recovery_locked,    // recovery mode
   output logic      [4:0]      ratio_code          // active ratio code
);
   if (PROG_N_MIN == 8'h00 || PROG_M_MIN == 7'h00)
      $error("cksr_regs: divider minimums must be nonzero");

   logic [7:0] skew_q;
   logic [7:0] rec_n;
   logic [7:0] rec_m_q;
   logic [7:0] prog_n;
   logic       wr_skew;
   logic       wr_rec_n;
   logic       wr_rec_m;
   logic       wr_prog_n;
   logic       take_timeout;
   logic       take_rec;
   logic       prog_ok;
   logic       take_prog;

   // address decode of register writes
   assign wr_skew   = reg_wr.wr && reg_wr.addr == OFS_SKEW;
   assign wr_rec_n  = reg_wr.wr && reg_wr.addr == OFS_REC_N;
   assign wr_rec_m  = reg_wr.wr && reg_wr.addr == OFS_REC_M;
   assign wr_prog_n = reg_wr.wr && reg_wr.addr == OFS_PROG_N;

   cksr_byte_reg #(.WIDTH(8), .RESET(RST_SKEW)) u_skew (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_skew),
      .wdata   (reg_wr.wdata),
      .q       (skew_q)
   );
   cksr_byte_reg #(.WIDTH(8), .RESET(RST_REC_N)) u_rec_n (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_rec_n),
      .wdata   (reg_wr.wdata),
      .q       (rec_n)
   );
   cksr_byte_reg #(.WIDTH(8), .RESET(RST_REC_M)) u_rec_m (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_rec_m),
      .wdata   (reg_wr.wdata),
      .q       (rec_m_q)
   );
   cksr_byte_reg #(.WIDTH(8), .RESET(RST_PROG_N)) u_prog_n (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr      (wr_prog_n),
      .wdata   (reg_wr.wdata),
      .q       (prog_n)
   );

   // load requests, time-out first, then recovery, then programmed
   assign take_timeout = watchdog_timeout && watchdog_enable
                         && !recovery_locked;
   assign take_rec  = (wr_rec_n || wr_rec_m) && !recovery_locked;
   assign prog_ok   = prog_n >= PROG_N_MIN
                      && programmed_divider_m >= PROG_M_MIN;
   assign take_prog = prog_m_wr && prog_freq_enable && prog_ok
                      && !recovery_locked;

   // skew fields; reserved bits never leave the block
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cpu_skew                  <= 3'h0;
         graphics_port_clock_delay <= 2'h0;
      end
      else if (ce)
      begin
         cpu_skew                  <= skew_q[CPU_SKEW_MSB:CPU_SKEW_LSB];
         graphics_port_clock_delay <= skew_q[GFX_SKEW_MSB:GFX_SKEW_LSB];
      end
   end

   // recovery lock, released only by reset or by clearing the watchdog enable
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         recovery_locked <= 1'b0;
      else if (ce)
      begin
         if (!watchdog_enable)
            recovery_locked <= 1'b0;
         else if (take_timeout)
            recovery_locked <= 1'b1;
      end
   end

   // frequency target and its load pulse
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         freq_target <= '0;
         freq_load   <= 1'b0;
      end
      else if (ce)
      begin
         freq_load <= take_timeout || take_rec || take_prog;
         if (take_timeout)
         begin
            freq_target.from_strap <= !rec_m_q[REC_SEL_BIT];
            freq_target.div_n      <= rec_n;
            freq_target.div_m      <= rec_m_q[DIV_M_MSB:0];
         end
         else if (take_rec)
         begin
            // new bytes go straight to the synthesizer
            freq_target.from_strap <= 1'b0;
            freq_target.div_n <= wr_rec_n ? reg_wr.wdata : rec_n;
            freq_target.div_m <= wr_rec_m ? reg_wr.wdata[DIV_M_MSB:0]
                                          : rec_m_q[DIV_M_MSB:0];
         end
         else if (take_prog)
         begin
            freq_target.from_strap <= 1'b0;
            freq_target.div_n      <= prog_n;
            freq_target.div_m      <= programmed_divider_m;
         end
      end
   end

   // ratio source follows the override bit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ratio_code <= 5'h00;
      else if (ce)
         ratio_code <= ratio_source_override ? sw_select_code
                                             : strap_frequency_code;
   end

   // read mux, reserved and unmapped bits read zero
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (ce)
      begin
         case (reg_raddr)
            OFS_SKEW:   reg_rdata <= skew_q & 8'he3;
            OFS_REC_N:  reg_rdata <= rec_n;
            OFS_REC_M:  reg_rdata <= rec_m_q;
            OFS_PROG_N: reg_rdata <= prog_n;
            default:    reg_rdata <= 8'h00;
         endcase
      end
   end

   sequence s_timeout;
      ce && take_timeout;
   endsequence
   sequence s_loaded;
      ##1 freq_load;
   endsequence

   skew_cpu_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_skew ##1 ce |=> cpu_skew == $past(reg_wr.wdata[7:5], 2))
      else $error("cpu skew does not follow written field");
   skew_gfx_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_skew ##1 ce |=> graphics_port_clock_delay
         == $past(reg_wr.wdata[1:0], 2))
      else $error("graphics skew does not follow written field");
   rec_source_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_timeout |=> freq_target.from_strap == !$past(rec_m_q[7]))
      else $error("recovery source select not honoured");
   timeout_load_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_timeout |-> s_loaded ##0 recovery_locked)
      else $error("time-out did not load and lock");
   rec_div_a: assert property (@(posedge ref_clk) disable iff (rst)
      s_timeout |=> freq_target.div_n == $past(rec_n)
         && freq_target.div_m == $past(rec_m_q[6:0]))
      else $error("recovery dividers not applied");
   ratio_src_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce |=> ratio_code == ($past(ratio_source_override)
         ? $past(sw_select_code) : $past(strap_frequency_code)))
      else $error("ratio code from wrong source");
   rec_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && take_rec |-> s_loaded)
      else $error("recovery divider write did not change frequency");
   prog_load_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && take_prog && !take_timeout && !take_rec
      |=> freq_load && freq_target.div_n == $past(prog_n))
      else $error("programmed dividers not loaded");
   prog_n_only_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && wr_prog_n && !prog_m_wr && !take_timeout && !take_rec
      |=> !freq_load)
      else $error("programmed N alone started a load");
   // while locked no load pulse and no target change may reach the outputs
   lock_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      ce && recovery_locked && watchdog_enable
      |=> !freq_load && $stable(freq_target) && recovery_locked)
      else $error("recovery lock let a change through");
   reset_zero_a: assert property (@(posedge ref_clk)
      rst |=> reg_rdata == 8'h00 && cpu_skew == 3'h0 && !freq_load
         && !recovery_locked && freq_target == '0)
      else $error("state not zero after reset");
endmodule
`default_nettype wire

// *** testbench/cksr_host.sv ***
// Purpose: host model that reads and writes the register slice
// Assumes: one byte a transfer, launched just after a clock edge
// Notes: released write fields carry inverted values, never stale ones; wr_pair puts the inverted M byte in both address and data
`timescale 1ns/1ps
`default_nettype none
module cksr_host
   import cksr_pkg::*;
(
   input  wire logic           ref_clk,   // system clock
   output var  cksr_write_type reg_wr,    // register write
   output var  logic [7:0]     reg_raddr, // read address
   input  wire logic [7:0]     reg_rdata  // read data
);
   // idle port at time zero
   initial
   begin
      reg_wr = '0;
      reg_raddr = 8'h00;
   end

   // one write strobe, held for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= '{1'b1, a, d};
      @(posedge ref_clk);
      reg_wr <= '{1'b0, ~a, ~d};
   endtask

   // recovery dividers sent back to back so no half pair lingers
   task automatic wr_pair(input logic [7:0] n, input logic [7:0] m);
      @(posedge ref_clk);
      reg_wr <= '{1'b1, OFS_REC_N, n};
      @(posedge ref_clk);
      reg_wr <= '{1'b1, OFS_REC_M, m};
      @(posedge ref_clk);
      reg_wr <= '{1'b0, ~m, ~m};
   endtask

   // read data is registered, so take it one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_raddr <= a;
      @(posedge ref_clk);
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// Purpose: self-checking bench for the skew and recovery register slice
// Assumes: host model drives the register port
// Notes: expected values are worked out from the register behaviour
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb
   import cksr_pkg::*;
;
   logic ref_clk = 0, rst = 1, ce = 1, watchdog_timeout = 0;
   logic watchdog_enable = 0, prog_freq_enable = 0, prog_m_wr = 0;
   logic ratio_source_override = 0;
   logic [6:0] programmed_divider_m = 7'h00;
   logic [4:0] strap_frequency_code = 5'h13, sw_select_code = 5'h0c;
   logic [7:0] reg_raddr, reg_rdata, d;
   logic [4:0] ratio_code;
   logic [2:0] cpu_skew;
   logic [1:0] graphics_port_clock_delay;
   logic freq_load, recovery_locked;
   cksr_write_type reg_wr;
   cksr_target_type freq_target;
   int n_errors = 0, n_compared = 0, cycles = 0;

   cksr_host host (.ref_clk, .reg_wr, .reg_raddr, .reg_rdata);
   cksr_regs DUT (.ref_clk, .rst, .ce, .reg_wr, .reg_raddr, .reg_rdata,
      .watchdog_timeout, .watchdog_enable, .prog_freq_enable, .prog_m_wr,
      .programmed_divider_m, .ratio_source_override, .strap_frequency_code,
      .sw_select_code, .cpu_skew, .graphics_port_clock_delay, .freq_target,
      .freq_load, .recovery_locked, .ratio_code);

   // clock and hang guard
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_errors++;
         test_done();
      end
   end

   task test_done();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // programmed M byte strobe, then look at the load pulse
   task prog_m(input logic [6:0] m, input logic exp);
      @(posedge ref_clk);
      prog_m_wr <= 1'b1;
      programmed_divider_m <= m;
      @(posedge ref_clk);
      prog_m_wr <= 1'b0;
      #1 `CHK(freq_load, exp)
   endtask

   // watchdog expiry strobe, then look at the load pulse
   task tmo(input logic exp);
      @(posedge ref_clk);
      watchdog_timeout <= 1'b1;
      @(posedge ref_clk);
      watchdog_timeout <= 1'b0;
      #1 `CHK(freq_load, exp)
   endtask

   // main sequence
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      #1 `CHK(freq_target, 16'h0000)
      for (int a = 10; a < 15; a++)
      begin
         host.rd(8'(a), d);
         `CHK(d, 8'h00)
      end
      `CHK(ratio_code, 5'h13)
      for (int i = 0; i < 8; i++)
      begin
         host.wr(OFS_SKEW, {3'(i), 3'h7, 2'(i)});
         host.rd(OFS_SKEW, d);
         `CHK(d, {3'(i), 3'h0, 2'(i)})
         `CHK(cpu_skew, 3'(i))
         `CHK(graphics_port_clock_delay, 2'(i))
      end
      host.wr(8'h0e, 8'hff);
      host.rd(8'h0e, d);
      `CHK(d, 8'h00)
      host.wr(OFS_REC_N, 8'h5a);
      #1 `CHK(freq_load, 1'b1)
      `CHK(freq_target, {1'b0, 8'h5a, 7'h00})
      host.wr(OFS_REC_M, 8'h85);
      #1 `CHK(freq_load, 1'b1)
      `CHK(freq_target, {1'b0, 8'h5a, 7'h05})
      host.rd(OFS_REC_M, d);
      `CHK(d, 8'h85)
      host.wr(OFS_PROG_N, 8'h20);
      #1 `CHK(freq_load, 1'b0)
      prog_m(7'h11, 1'b0);
      @(posedge ref_clk);
      prog_freq_enable <= 1'b1;
      ratio_source_override <= 1'b1;
      prog_m(7'h11, 1'b1);
      `CHK(freq_target, {1'b0, 8'h20, 7'h11})
      `CHK(ratio_code, 5'h0c)
      prog_m(7'h00, 1'b0);
      @(posedge ref_clk);
      watchdog_enable <= 1'b1;
      tmo(1'b1);
      `CHK(recovery_locked, 1'b1)
      `CHK(freq_target, {1'b0, 8'h5a, 7'h05})
      host.wr(OFS_REC_N, 8'h33);
      #1 `CHK(freq_load, 1'b0)
      prog_m(7'h11, 1'b0);
      tmo(1'b0);
      `CHK(freq_target, {1'b0, 8'h5a, 7'h05})
      @(posedge ref_clk);
      watchdog_enable <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 `CHK(recovery_locked, 1'b0)
      host.wr_pair(8'h33, 8'h05);
      #1 `CHK(freq_target, {1'b0, 8'h33, 7'h05})
      @(posedge ref_clk);
      watchdog_enable <= 1'b1;
      tmo(1'b1);
      `CHK(freq_target, {1'b1, 8'h33, 7'h05})
      // clock enable low: a skew write is dropped and all state holds
      @(posedge ref_clk);
      ce <= 1'b0;
      host.wr(OFS_SKEW, 8'h00);
      repeat (2) @(posedge ref_clk);
      #1 `CHK(cpu_skew, 3'h7)
      `CHK(recovery_locked, 1'b1)
      @(posedge ref_clk);
      ce <= 1'b1;
      host.rd(OFS_SKEW, d);
      `CHK(d, 8'he3)
      // reset in mid-run clears the lock, the target and the stored bytes
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      #1 `CHK(recovery_locked, 1'b0)
      `CHK(freq_target, 16'h0000)
      host.rd(OFS_REC_N, d);
      `CHK(d, 8'h00)
      test_done();
   end
endmodule
`default_nettype wire
